// [dv/trc_front_model.sv]
`timescale 1ns/1ps
module trc_front_model (
  input  wire logic        i_clock,
  input  wire logic        i_srst,
  input  wire logic [3:0]  i_lag,
  input  wire logic        i_tdc_start,
  input  wire logic        i_tdc_stop,
  output logic             o_slow_osc,
  output logic             o_tdc_done,
  output logic [31:0]      o_tdc_value
);
  logic [7:0] span;
  logic [3:0] lag;
  logic       run;

  // free-running and deliberately off the system clock grid
  initial begin
    o_slow_osc = 1'b0;
    forever #395 o_slow_osc = ~o_slow_osc;
  end

  always_ff @(posedge i_clock) begin
    if (i_srst || i_tdc_start) begin
      run  <= !i_srst;
      span <= 8'h0;
    end else if (run && i_tdc_stop) begin
      run <= 1'b0;
    end else if (run) begin
      span <= span + 8'h1;
    end
  end

  // i_lag picks a prompt or a slow conversion
  always_ff @(posedge i_clock) begin
    if (i_srst)
      lag <= 4'h0;
    else if (run && i_tdc_stop)
      lag <= i_lag;
    else if (lag != 4'h0)
      lag <= lag - 4'h1;
  end

  assign o_tdc_done  = (lag == 4'h1);
  // value bus shows garbage outside the done pulse
  assign o_tdc_value = o_tdc_done ? {8'h0, span, 16'h0} : ~{8'h0, span, 16'h0};
endmodule

// [dv/trc_top_monitor.sv]
`timescale 1ns/1ps
module trc_top_monitor (
  input wire logic        i_clock,
  input wire logic        i_srst,
  input wire logic [7:0]  i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic        i_reg_wr,
  input wire logic        i_reg_rd,
  input wire logic [31:0] o_reg_rdata,
  input wire logic        i_seq_trigger,
  input wire logic        i_meas_req,
  input wire logic        o_second_pass_en,
  input wire logic        o_four_wire,
  input wire logic        o_fast_osc_en,
  input wire logic        o_tdc_start,
  input wire logic        o_tdc_stop,
  input wire logic        i_tdc_done,
  input wire logic [31:0] i_tdc_value,
  input wire logic        o_cal_busy
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_srst);
  logic [2:0]  rate;
  logic [3:0]  cfg;
  logic [1:0]  age;
  logic [31:0] cal;

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      rate <= 3'h0;
      cfg  <= 4'h0;
    end else if (i_reg_wr && i_reg_addr == 8'hc5) begin
      rate <= i_reg_wdata[2:0];
    end else if (i_reg_wr && i_reg_addr == 8'hc7) begin
      cfg <= i_reg_wdata[3:0];
    end
  end

  // outputs are compared only once a config write has settled
  always_ff @(posedge i_clock) begin
    if (i_srst)
      age <= 2'h3;
    else if (i_reg_wr && i_reg_addr == 8'hc7)
      age <= 2'h0;
    else if (age != 2'h3)
      age <= age + 2'h1;
  end

  always_ff @(posedge i_clock) begin
    if (i_srst)
      cal <= 32'h0;
    else if (i_tdc_done && o_cal_busy)
      cal <= i_tdc_value;
  end

  sequence window_s;
    ##[30:34] o_tdc_stop;
  endsequence

  rdata_idle_a: assert property (
    !$past(i_reg_rd) |-> o_reg_rdata == 32'h0)
    else $error("read data outside answer cycle");
  cal_read_a: assert property (
    $past(i_reg_rd) && $past(i_reg_addr) == 8'he4 && !$past(i_tdc_done)
    |-> o_reg_rdata == cal)
    else $error("calibration value not returned");
  four_period_a: assert property (o_tdc_start |-> window_s)
    else $error("window is not four slow periods");
  start_ctx_a: assert property (
    o_tdc_start |-> o_fast_osc_en && o_cal_busy)
    else $error("start without oscillator or busy");
  osc_req_a: assert property (
    $past(i_meas_req) && !$past(i_srst) |-> o_fast_osc_en)
    else $error("oscillator off while requested");
  osc_off_a: assert property (
    !o_cal_busy && !$past(o_cal_busy) && !$past(o_cal_busy, 2)
    && !$past(i_meas_req) && !$past(i_meas_req, 2) |-> !o_fast_osc_en)
    else $error("oscillator on without need");
  launch_src_a: assert property (
    $rose(o_cal_busy) |-> rate != 3'h0
    && ($past(i_seq_trigger, 2) || $past(i_seq_trigger, 3)))
    else $error("calibration without trigger or rate");
  busy_end_a: assert property (
    o_cal_busy && i_tdc_done |-> ##[1:2] !o_cal_busy)
    else $error("busy held after result");
  pass_cfg_a: assert property (
    age == 2'h3 |-> o_second_pass_en == (cfg[2:0] != 3'h0)
    && o_four_wire == cfg[3])
    else $error("pass or wiring output wrong");
endmodule

// [dv/trc_top_tb_top.sv]
`timescale 1ns/1ps
module trc_top_tb_top;
  logic        i_clock = 1'b0, i_srst = 1'b1, i_reg_wr = 1'b0;
  logic        i_reg_rd = 1'b0, i_tm_valid = 1'b0, i_tm_pass = 1'b0;
  logic        i_tof_valid = 1'b0, i_seq_trigger = 1'b0, i_meas_req = 1'b0;
  logic        o_second_pass_en, o_four_wire, i_slow_osc, o_fast_osc_en;
  logic        o_tdc_start, o_tdc_stop, i_tdc_done, o_cal_busy, fw, sp;
  logic [3:0]  i_tm_slot = 4'h0, lag = 4'h1;
  logic [4:0]  i_tof_index = 5'h0;
  logic [7:0]  i_reg_addr = 8'h0;
  logic [31:0] i_reg_wdata = 32'h0, i_tm_data = 32'h0, i_tof_data = 32'h0;
  logic [31:0] o_reg_rdata, i_tdc_value, exp_cal, n = 32'h0;
  logic [31:0] mem [28];
  int          num_errors = 0, tests_run = 0;
  int          steps [8] = '{4, 1, 2, 5, 10, 20, 50, 100};

  always #50 i_clock = ~i_clock;
  always @(posedge i_clock) begin
    if (i_tdc_done)
      exp_cal <= i_tdc_value;
  end

  trc_top dut_u (.*);
  trc_front_model model_u (
    .i_clock, .i_srst, .i_lag(lag), .i_tdc_start(o_tdc_start),
    .i_tdc_stop(o_tdc_stop), .o_slow_osc(i_slow_osc),
    .o_tdc_done(i_tdc_done), .o_tdc_value(i_tdc_value));

  task automatic end_of_test;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    tests_run++;
    if (got !== want) begin
      num_errors++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, want);
    end
  endtask

  task automatic tick;
    @(posedge i_clock);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    i_reg_wr    <= 1'b1;
    @(posedge i_clock);
    i_reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] want);
    i_reg_addr <= a;
    i_reg_rd   <= 1'b1;
    @(posedge i_clock);
    i_reg_rd <= 1'b0;
    #1;
    chk(o_reg_rdata, want);
  endtask

  task automatic trig;
    i_seq_trigger <= 1'b1;
    @(posedge i_clock);
    i_seq_trigger <= 1'b0;
    #1;
  endtask

  // buffer word a result should land in, 31 when it must be dropped
  function automatic int where(input logic p, input logic [3:0] s);
    if (s > 4'hd || (p && !sp) || (s > 4'h4 && !fw))
      return 31;
    if (s < 4'h5)
      return p ? 5 + s : s;
    return p ? 14 + s : 5 + s;
  endfunction

  task automatic post(input logic p, input logic [3:0] s);
    int k;
    k = where(p, s);
    n = n + 32'h0101_0001;
    if (k < 28)
      mem[k] = n;
    i_tm_valid <= 1'b1;
    i_tm_pass  <= p;
    i_tm_slot  <= s;
    i_tm_data  <= n;
    @(posedge i_clock);
    i_tm_valid <= 1'b0;
    i_tm_data  <= ~n;
    #1;
  endtask

  task automatic round(input logic [31:0] cfg);
    wr(8'hc7, cfg);
    fw = cfg[3];
    sp = cfg[2:0] != 3'h0;
    for (int p = 0; p < 2; p++) begin
      for (int s = 0; s < 15; s++) begin
        post(p[0], s[3:0]);
      end
    end
    wr(8'h81, 32'hdead_beef);
    chk({30'h0, o_second_pass_en, o_four_wire}, {30'h0, sp, fw});
    for (int i = 0; i < 28; i++) begin
      rd(8'h80 + i[7:0], mem[i]);
    end
  endtask

  initial begin
    repeat (20) @(posedge i_clock);
    i_srst <= 1'b0;
    #1;
    rd(8'hc5, 32'h0);
    rd(8'hc7, 32'h0);
    rd(8'he4, 32'h0);
    rd(8'hf0, 32'h0);
    for (int i = 0; i < 28; i++) begin
      mem[i] = 32'hc0de_0000 + i;
      i_tof_valid <= 1'b1;
      i_tof_index <= i[4:0];
      i_tof_data  <= mem[i];
      tick;
    end
    i_tof_valid <= 1'b0;
    round(32'h0);
    round(32'hb);
    round(32'h3);
    i_meas_req <= 1'b1;
    repeat (2) tick;
    chk({31'h0, o_fast_osc_en}, 32'h1);
    i_meas_req <= 1'b0;
    repeat (3) tick;
    chk({31'h0, o_fast_osc_en}, 32'h0);
    for (int c = 0; c < 8; c++) begin
      wr(8'hc5, c);
      lag <= c[0] ? 4'h1 : 4'h9;
      repeat (steps[c] - 1) trig;
      repeat (2) tick;
      chk({31'h0, o_cal_busy}, 32'h0);
      trig;
      repeat (2) tick;
      chk({31'h0, o_cal_busy}, c != 0);
      for (int k = 0; k < 300 && o_cal_busy === 1'b1; k++)
        tick;
      chk({31'h0, o_cal_busy}, 32'h0);
      if (c != 0) begin
        rd(8'he8, 32'h2);
        rd(8'he4, exp_cal);
        rd(8'he8, 32'h0);
        // four slow periods of 790 ns span 28 to 31 whole cycles
        chk({26'h0, exp_cal[23:18]}, 32'h7);
      end
    end
    end_of_test;
  end

  initial begin
    #1000000;
    num_errors++;
    end_of_test;
  end
endmodule

bind trc_top trc_top_monitor mon_u (.*);

// [verilog/trc_cal_if.sv]
`timescale 1ns/1ps

interface trc_cal_if;
  logic launch;
  logic go;
  logic tdc_start;
  logic tdc_stop;
  logic done;

  modport sched_mp (
    output launch
  );

  modport timer_mp (
    input  go,
    output tdc_start,
    output tdc_stop,
    output done
  );

  modport ctrl_mp (
    input  launch,
    input  tdc_start,
    input  tdc_stop,
    input  done,
    output go
  );
endinterface

// [verilog/trc_cal_sched.sv]
`timescale 1ns/1ps
`include "trc_consts.svh"

module trc_cal_sched (
  input  wire logic       i_clock,
  input  wire logic       i_srst,
  input  wire logic       i_seq_trigger,
  input  wire logic [2:0] i_rate_code,
  trc_cal_if.sched_mp     cal
);

  logic [6:0] count;
  logic [6:0] rate;
  logic       launch;

  always_comb begin
    case (i_rate_code)
      3'h1:    rate = 7'h01;
      3'h2:    rate = 7'h02;
      3'h3:    rate = 7'h05;
      3'h4:    rate = 7'h0a;
      3'h5:    rate = 7'h14;
      3'h6:    rate = 7'h32;
      3'h7:    rate = 7'h64;
      default: rate = 7'h00;
    endcase
  end

  // a lowered rate takes effect at once thanks to the >= compare
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      count  <= 7'h00;
      launch <= 1'b0;
    end else begin
      launch <= 1'b0;
      if (rate == 7'h00) begin
        count <= 7'h00;
      end else if (i_seq_trigger) begin
        if (count + 7'h01 >= rate) begin
          count  <= 7'h00;
          launch <= 1'b1;
        end else begin
          count <= count + 7'h01;
        end
      end
    end
  end

  assign cal.launch = launch;

endmodule

// [verilog/trc_consts.svh]
`ifndef TRC_CONSTS_SVH
`define TRC_CONSTS_SVH

// register bus
`define TRC_ADDR_W          8
`define TRC_DATA_W          32
`define TRC_OFS_CLK_PWR     8'hc5
`define TRC_OFS_TEMP_CFG    8'hc7
`define TRC_OFS_CAL_RESULT  8'he4
`define TRC_OFS_CAL_STATUS  8'he8

// result buffer window and word indices (offset minus buffer base)
`define TRC_BUF_BASE        8'h80
`define TRC_BUF_LAST        8'h9b
`define TRC_BUF_WORDS       28
`define TRC_IDX_PASS2       5'h05
`define TRC_IDX_CORR1       5'h0a
`define TRC_IDX_CORR2       5'h13
`define TRC_BASIC_SLOTS     4'h5
`define TRC_LAST_SLOT       4'hd

// field positions
`define TRC_CAL_RATE_MSB    2
`define TRC_CAL_RATE_LSB    0
`define TRC_PAUSE_MSB       2
`define TRC_PAUSE_LSB       0
`define TRC_WIRE_BIT        3
`define TRC_ST_BUSY_BIT     0
`define TRC_ST_NEW_BIT      1

// reset values
`define TRC_CLK_PWR_RST     32'h0000_0000
`define TRC_TEMP_CFG_RST    32'h0000_0000
`define TRC_CAL_RESULT_RST  32'h0000_0000

// timing
`define TRC_CAL_PERIODS     3'h4
`define TRC_CLK_PERIOD_NS   100
`define TRC_SETTLE_NS       1000
`define TRC_SETTLE_CYC \
  ((`TRC_SETTLE_NS + `TRC_CLK_PERIOD_NS - 1) / `TRC_CLK_PERIOD_NS)

`endif

// [verilog/trc_period_timer.sv]
`timescale 1ns/1ps
`include "trc_consts.svh"

module trc_period_timer (
  input  wire logic   i_clock,
  input  wire logic   i_srst,
  input  wire logic   i_slow_osc,
  trc_cal_if.timer_mp cal
);

  logic       sync1;
  logic       sync2;
  logic       sync2_d;
  logic       armed;
  logic       running;
  logic [2:0] edges;
  logic       start_p;
  logic       stop_p;
  logic       rise;

  always_ff @(posedge i_clock) begin
    sync1   <= i_slow_osc;
    sync2   <= sync1;
    sync2_d <= sync2;
  end

  assign rise = sync2 & ~sync2_d;

  // the window opens on a rising edge so whole periods are timed
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      armed   <= 1'b0;
      running <= 1'b0;
      edges   <= 3'h0;
      start_p <= 1'b0;
      stop_p  <= 1'b0;
    end else begin
      start_p <= 1'b0;
      stop_p  <= 1'b0;
      if (cal.go && !armed && !running) begin
        armed <= 1'b1;
      end else if (armed && rise) begin
        armed   <= 1'b0;
        running <= 1'b1;
        edges   <= 3'h0;
        start_p <= 1'b1;
      end else if (running && rise) begin
        if (edges + 3'h1 == `TRC_CAL_PERIODS) begin
          running <= 1'b0;
          stop_p  <= 1'b1;
        end
        edges <= edges + 3'h1;
      end
    end
  end

  assign cal.tdc_start = start_p;
  assign cal.tdc_stop  = stop_p;
  assign cal.done      = stop_p;

endmodule

// [verilog/trc_pkg.sv]
package trc_pkg;

  typedef enum logic [1:0] {
    st_idle   = 2'b00,
    st_settle = 2'b01,
    st_timing = 2'b11,
    st_result = 2'b10
  } trc_cal_state_t;

  typedef logic [31:0] trc_word_t;

endpackage

// [verilog/trc_top.sv]
// Overview of operation
// - first pass posts five words at 0x080-0x084
// - second pass posts five words at 0x085-0x089
// - second-pass words untouched when pause is zero
// - correction words posted only in four-wire mode
// - corrections: ref, four cold, four hot each
// - result words are 32-bit unsigned 16.16 times
// - fast oscillator on only while measurement or calibration needs it
// - calibration times exactly four slow oscillator periods
// - interval field picks trigger count, zero disables
// - raw calibration value stored at 0x0E4
// - zero pause runs one pass, else two
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`include "trc_consts.svh"

module trc_top (
  input  wire logic        i_clock,
  input  wire logic        i_srst,
  // register port
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic      [31:0] o_reg_rdata,
  // temperature frontend results
  input  wire logic        i_tm_valid,
  input  wire logic        i_tm_pass,
  input  wire logic [3:0]  i_tm_slot,
  input  wire logic [31:0] i_tm_data,
  // flight-time results share the buffer
  input  wire logic        i_tof_valid,
  input  wire logic [4:0]  i_tof_index,
  input  wire logic [31:0] i_tof_data,
  // sequencer and measurement demand
  input  wire logic        i_seq_trigger,
  input  wire logic        i_meas_req,
  output logic             o_second_pass_en,
  output logic             o_four_wire,
  // clocks and time-to-digital converter
  input  wire logic        i_slow_osc,
  output logic             o_fast_osc_en,
  output logic             o_tdc_start,
  output logic             o_tdc_stop,
  input  wire logic        i_tdc_done,
  input  wire logic [31:0] i_tdc_value,
  output logic             o_cal_busy
);

  localparam logic [7:0] settle_cyc = 8'(`TRC_SETTLE_CYC);

  trc_cal_if cal ();

  trc_pkg::trc_word_t       buffer [0:`TRC_BUF_WORDS-1];
  trc_pkg::trc_word_t       clk_pwr_cfg;
  trc_pkg::trc_word_t       temp_cfg;
  trc_pkg::trc_word_t       cal_result;
  trc_pkg::trc_cal_state_t  state;
  trc_pkg::trc_cal_state_t  next_state;
  logic [7:0]               settle_count;
  logic                     result_new;
  logic [2:0]               pause;
  logic                     wire4;
  logic [2:0]               rate_code;
  logic                     tm_ok;
  logic [4:0]               tm_index;
  logic [4:0]               slot5;
  logic [7:0]               buf_ofs;
  logic                     buf_hit;
  logic                     store_cal;
  trc_pkg::trc_word_t       next_rdata;

  assign pause     = temp_cfg[`TRC_PAUSE_MSB:`TRC_PAUSE_LSB];
  assign wire4     = temp_cfg[`TRC_WIRE_BIT];
  assign rate_code = clk_pwr_cfg[`TRC_CAL_RATE_MSB:`TRC_CAL_RATE_LSB];

  trc_cal_sched u_sched (
    .i_clock       (i_clock),
    .i_srst        (i_srst),
    .i_seq_trigger (i_seq_trigger),
    .i_rate_code   (rate_code),
    .cal           (cal.sched_mp)
  );

  trc_period_timer u_timer (
    .i_clock    (i_clock),
    .i_srst     (i_srst),
    .i_slow_osc (i_slow_osc),
    .cal        (cal.timer_mp)
  );

  // configuration registers; every other write address is read-only
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      clk_pwr_cfg <= `TRC_CLK_PWR_RST;
    end else if (i_reg_wr && i_reg_addr == `TRC_OFS_CLK_PWR) begin
      clk_pwr_cfg <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      temp_cfg <= `TRC_TEMP_CFG_RST;
    end else if (i_reg_wr && i_reg_addr == `TRC_OFS_TEMP_CFG) begin
      temp_cfg <= i_reg_wdata;
    end
  end

  // pass count and wiring are told to the discharge sequencer
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_second_pass_en <= 1'b0;
    end else begin
      o_second_pass_en <= (pause != 3'h0);
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_four_wire <= 1'b0;
    end else begin
      o_four_wire <= wire4;
    end
  end

  // map a frontend slot and pass onto a buffer word
  // dropped words keep their old contents, which firmware may rely on
  always_comb begin
    slot5 = {1'b0, i_tm_slot};
    tm_ok = i_tm_valid && (i_tm_slot <= `TRC_LAST_SLOT);
    if (i_tm_pass && pause == 3'h0) begin
      tm_ok = 1'b0;
    end
    if (i_tm_slot >= `TRC_BASIC_SLOTS && !wire4) begin
      tm_ok = 1'b0;
    end
    if (i_tm_slot < `TRC_BASIC_SLOTS) begin
      if (i_tm_pass) begin
        tm_index = `TRC_IDX_PASS2 + slot5;
      end else begin
        tm_index = slot5;
      end
    end else begin
      if (i_tm_pass) begin
        tm_index = `TRC_IDX_CORR2 + slot5 - 5'h05;
      end else begin
        tm_index = `TRC_IDX_CORR1 + slot5 - 5'h05;
      end
    end
  end

  // one shared buffer; a flight-time write wins a collision because
  // the two never run together in a healthy sequence
  always_ff @(posedge i_clock) begin
    if (i_tof_valid && i_tof_index < 5'(`TRC_BUF_WORDS)) begin
      buffer[i_tof_index] <= i_tof_data;
    end else if (tm_ok) begin
      buffer[tm_index] <= i_tm_data;
    end
  end

  // calibration sequencing
  // a launch that arrives while busy is dropped, not queued
  always_comb begin
    next_state = state;
    case (state)
      trc_pkg::st_idle: begin
        if (cal.launch) begin
          next_state = trc_pkg::st_settle;
        end
      end
      trc_pkg::st_settle: begin
        if (settle_count == 8'h00) begin
          next_state = trc_pkg::st_timing;
        end
      end
      trc_pkg::st_timing: begin
        if (cal.done) begin
          next_state = trc_pkg::st_result;
        end
      end
      trc_pkg::st_result: begin
        if (i_tdc_done) begin
          next_state = trc_pkg::st_idle;
        end
      end
      default: next_state = trc_pkg::st_idle;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      state <= trc_pkg::st_idle;
    end else begin
      state <= next_state;
    end
  end

  // give the fast oscillator time to settle before timing starts
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      settle_count <= 8'h00;
    end else if (state == trc_pkg::st_idle) begin
      settle_count <= settle_cyc - 8'h01;
    end else if (state == trc_pkg::st_settle && settle_count != 8'h00) begin
      settle_count <= settle_count - 8'h01;
    end
  end

  assign cal.go = (state == trc_pkg::st_settle) && (settle_count == 8'h00);

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_tdc_start <= 1'b0;
    end else begin
      o_tdc_start <= cal.tdc_start;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_tdc_stop <= 1'b0;
    end else begin
      o_tdc_stop <= cal.tdc_stop;
    end
  end

  // busy follows the next state so it rises with the oscillator enable
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_cal_busy <= 1'b0;
    end else begin
      o_cal_busy <= (next_state != trc_pkg::st_idle);
    end
  end

  // power follows demand only; no idle keep-alive
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_fast_osc_en <= 1'b0;
    end else begin
      o_fast_osc_en <= i_meas_req ||
                       (next_state != trc_pkg::st_idle);
    end
  end

  // raw value stored as is; scaling is left to firmware
  assign store_cal = (state == trc_pkg::st_result) && i_tdc_done;

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      cal_result <= `TRC_CAL_RESULT_RST;
    end else if (store_cal) begin
      cal_result <= i_tdc_value;
    end
  end

  // new-result flag: a store in the same cycle as the read wins
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      result_new <= 1'b0;
    end else if (store_cal) begin
      result_new <= 1'b1;
    end else if (i_reg_rd && i_reg_addr == `TRC_OFS_CAL_RESULT) begin
      result_new <= 1'b0;
    end
  end

  // read port
  // the buffer has no reset; unwritten words read back undefined
  assign buf_ofs = i_reg_addr - `TRC_BUF_BASE;
  assign buf_hit = (i_reg_addr >= `TRC_BUF_BASE) &&
                   (i_reg_addr <= `TRC_BUF_LAST);

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (buf_hit) begin
      next_rdata = buffer[buf_ofs[4:0]];
    end else begin
      case (i_reg_addr)
        `TRC_OFS_CLK_PWR:    next_rdata = clk_pwr_cfg;
        `TRC_OFS_TEMP_CFG:   next_rdata = temp_cfg;
        `TRC_OFS_CAL_RESULT: next_rdata = cal_result;
        `TRC_OFS_CAL_STATUS: begin
          next_rdata[`TRC_ST_BUSY_BIT] = (state != trc_pkg::st_idle);
          next_rdata[`TRC_ST_NEW_BIT]  = result_new;
        end
        default:             next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // data only in the cycle after the read strobe
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      o_reg_rdata <= 32'h0000_0000;
    end else if (i_reg_rd) begin
      o_reg_rdata <= next_rdata;
    end else begin
      o_reg_rdata <= 32'h0000_0000;
    end
  end

endmodule
